// ---- logic/pcg_pkg.sv ----
// Purpose: Constants and types for the peripheral clock gating control block
// Assumes: Register indices are word indices; byte address is four times the index
// Notes:   Gate bit positions and masks used by the register file and enables

package pcg_pkg;

    localparam int          NREG     = 12;
    localparam int          ADDR_W   = 18;
    localparam int          IDX_W    = 16;
    localparam int          DATA_W   = 16;

    // Word indices of the control registers
    localparam logic [IDX_W-1:0] IDX_PLL_STATUS   = 16'h7011;
    localparam logic [IDX_W-1:0] IDX_HS_PRESCALER = 16'h701a;
    localparam logic [IDX_W-1:0] IDX_LS_PRESCALER = 16'h701b;
    localparam logic [IDX_W-1:0] IDX_GATE_0       = 16'h701c;
    localparam logic [IDX_W-1:0] IDX_GATE_1       = 16'h701d;
    localparam logic [IDX_W-1:0] IDX_LOW_POWER    = 16'h701e;
    localparam logic [IDX_W-1:0] IDX_GATE_3       = 16'h7020;
    localparam logic [IDX_W-1:0] IDX_PLL_CONTROL  = 16'h7021;
    localparam logic [IDX_W-1:0] IDX_SYS_STATUS   = 16'h7022;
    localparam logic [IDX_W-1:0] IDX_WD_COUNTER   = 16'h7023;
    localparam logic [IDX_W-1:0] IDX_WD_KEY       = 16'h7025;
    localparam logic [IDX_W-1:0] IDX_WD_CONTROL   = 16'h7029;

    localparam logic [IDX_W-1:0] REG_INDEX [NREG] = '{
        IDX_PLL_STATUS, IDX_HS_PRESCALER, IDX_LS_PRESCALER, IDX_GATE_0,
        IDX_GATE_1, IDX_LOW_POWER, IDX_GATE_3, IDX_PLL_CONTROL,
        IDX_SYS_STATUS, IDX_WD_COUNTER, IDX_WD_KEY, IDX_WD_CONTROL};

    // Slots in the storage array
    localparam int          SLOT_PLL_STATUS  = 0;
    localparam int          SLOT_HS_PRESC    = 1;
    localparam int          SLOT_LS_PRESC    = 2;
    localparam int          SLOT_GATE_0      = 3;
    localparam int          SLOT_PLL_CONTROL = 7;

    // Gate bit positions in peripheral_clock_gate_0
    localparam int          BIT_CAN_B      = 15;
    localparam int          BIT_CAN_A      = 14;
    localparam int          BIT_SPORT_B    = 13;
    localparam int          BIT_SPORT_A    = 12;
    localparam int          BIT_UART_B     = 11;
    localparam int          BIT_UART_A     = 10;
    localparam int          BIT_SPI_A      = 8;
    localparam int          BIT_UART_C     = 5;
    localparam int          BIT_I2C        = 4;
    localparam int          BIT_CONVERTER  = 3;
    localparam int          BIT_TB_SYNC    = 2;

    localparam logic [DATA_W-1:0] GATE0_RW_MASK  = 16'hfd3c;
    localparam logic [DATA_W-1:0] GATE0_RESET    = 16'h0000;
    localparam logic [DATA_W-1:0] REG_RESET      = 16'h0000;
    localparam logic [DATA_W-1:0] PRESENT_ALL    = 16'hffff;
    localparam logic [DATA_W-1:0] LS_BITS        = 16'h3d30;
    localparam logic [DATA_W-1:0] HS_BITS        = 16'h0008;
    localparam logic [DATA_W-1:0] HALF_BITS      = 16'hc000;

    localparam int          PRESC_W        = 3;
    localparam int          DIV_W          = 4;

    localparam logic [1:0]  RESP_OKAY      = 2'b00;
    localparam logic [1:0]  RESP_SLVERR    = 2'b10;

    typedef enum logic [1:0] {
        WR_IDLE = 2'b01,
        WR_RESP = 2'b10
    } pcg_wr_state_e;

    typedef struct packed {
        logic can_b;
        logic can_a;
        logic sport_b;
        logic sport_a;
        logic uart_b;
        logic uart_a;
        logic spi_a;
        logic uart_c;
        logic i2c;
        logic converter;
    } pcg_clk_en_s;

endpackage

// ---- logic/pcg_clock_gate.sv ----
// Purpose: Peripheral clock gating control with AXI4-Lite register access
// Assumes: One clock; peripheral clocks leave as one-cycle enable pulses
// Notes:   Registers sit at byte address four times their word index
//
// Added by the designer: the AXI4-Lite interface to the registers.

`timescale 1ns/1ps

module pcg_clock_gate #(
    parameter logic [15:0] PRESENT_MASK = pcg_pkg::PRESENT_ALL
) (
    input  wire logic                        aclk,
    input  wire logic                        aresetn,
    input  wire logic [pcg_pkg::ADDR_W-1:0]  s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [pcg_pkg::ADDR_W-1:0]  s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        protected_write_enable,
    input  wire logic                        external_reset_pin_n,
    input  wire logic                        watchdog_reset,
    output logic                             system_clock_output,
    output pcg_pkg::pcg_clk_en_s             clk_en,
    output logic                             pwm_timebase_sync
);

    localparam int N = pcg_pkg::NREG;

    pcg_pkg::pcg_wr_state_e          wr_state;
    logic [pcg_pkg::ADDR_W-1:0]      aw_addr;
    logic                            aw_held;
    logic [15:0]                     w_data;
    logic [1:0]                      w_strb;
    logic                            w_held;
    logic [15:0]                     regs [N];
    logic [2:0]                      pin_sync;
    logic                            half_tick;
    logic [pcg_pkg::DIV_W-1:0]       ls_cnt;
    logic [pcg_pkg::DIV_W-1:0]       hs_cnt;
    logic                            ls_tick;
    logic                            hs_tick;
    logic [15:0]                     applied;
    logic [15:0]                     pulse;

    // Address decode
    wire [15:0]  wr_index  = aw_addr[pcg_pkg::ADDR_W-1:2];
    wire [15:0]  rd_index  = s_axi_araddr[pcg_pkg::ADDR_W-1:2];
    wire [N-1:0] wr_hit;
    wire [N-1:0] rd_hit;
    wire [15:0]  rd_sel [N];
    wire [15:0]  wr_mask [N];

    wire wr_go      = aw_held && w_held && (wr_state == pcg_pkg::WR_IDLE);
    wire wr_mapped  = |wr_hit;
    wire wr_allowed = wr_go && wr_mapped && protected_write_enable;
    wire ar_go      = s_axi_arvalid && s_axi_arready;
    wire [15:0] strb_mask = {{8{w_strb[1]}}, {8{w_strb[0]}}};

    // Pin reset counts once the second and third stages agree low
    wire pin_reset   = !pin_sync[1] && !pin_sync[2];
    wire pll_reset   = pin_reset || watchdog_reset;
    wire sys_reset   = !aresetn || pll_reset;

    // Gate register writable bits: reserved and absent bits stay zero
    wire [15:0] gate_mask = pcg_pkg::GATE0_RW_MASK & PRESENT_MASK;

    // Source tick per gate bit
    wire [15:0] src_tick = (pcg_pkg::HALF_BITS & {16{half_tick}})
                         | (pcg_pkg::LS_BITS & {16{ls_tick}})
                         | (pcg_pkg::HS_BITS & {16{hs_tick}});

    wire [pcg_pkg::PRESC_W-1:0] ls_field = regs[pcg_pkg::SLOT_LS_PRESC][2:0];
    wire [pcg_pkg::PRESC_W-1:0] hs_field = regs[pcg_pkg::SLOT_HS_PRESC][2:0];
    wire [pcg_pkg::DIV_W-1:0]   ls_last;
    wire [pcg_pkg::DIV_W-1:0]   hs_last;

    // Divide by twice the field, or by one when the field is zero
    assign ls_last = (ls_field == 3'h0) ? 4'h0 : {ls_field, 1'b0} - 4'h1;
    assign hs_last = (hs_field == 3'h0) ? 4'h0 : {hs_field, 1'b0} - 4'h1;

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_dec
            assign wr_hit[g]  = (wr_index == pcg_pkg::REG_INDEX[g]);
            assign rd_hit[g]  = (rd_index == pcg_pkg::REG_INDEX[g]);
            assign rd_sel[g]  = rd_hit[g] ? regs[g] : 16'h0000;
            assign wr_mask[g] = (g == pcg_pkg::SLOT_GATE_0) ? gate_mask : 16'hffff;
        end
    endgenerate

    logic [15:0] rd_word;
    always_comb begin
        rd_word = 16'h0000;
        for (int i = 0; i < N; i++) begin
            rd_word = rd_word | rd_sel[i];
        end
    end

    // Write address and data are taken independently
    assign s_axi_awready = !aw_held && (wr_state == pcg_pkg::WR_IDLE);
    assign s_axi_wready  = !w_held && (wr_state == pcg_pkg::WR_IDLE);
    assign s_axi_arready = !s_axi_rvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (wr_go) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 16'h0000;
            w_strb <= 2'b00;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata[15:0];
            w_strb <= s_axi_wstrb[1:0];
        end else if (wr_go) begin
            w_held <= 1'b0;
        end
    end

    // Write response state machine
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_state     <= pcg_pkg::WR_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= pcg_pkg::RESP_OKAY;
        end else begin
            case (wr_state)
                pcg_pkg::WR_IDLE: begin
                    if (wr_go) begin
                        wr_state     <= pcg_pkg::WR_RESP;
                        s_axi_bvalid <= 1'b1;
                        s_axi_bresp  <= wr_mapped ? pcg_pkg::RESP_OKAY
                                                  : pcg_pkg::RESP_SLVERR;
                    end
                end
                pcg_pkg::WR_RESP: begin
                    if (s_axi_bready) begin
                        wr_state     <= pcg_pkg::WR_IDLE;
                        s_axi_bvalid <= 1'b0;
                    end
                end
                default: begin
                    wr_state     <= pcg_pkg::WR_IDLE;
                    s_axi_bvalid <= 1'b0;
                end
            endcase
        end
    end

    // Read channel
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= pcg_pkg::RESP_OKAY;
        end else if (ar_go) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= {16'h0000, rd_word};
            s_axi_rresp  <= (|rd_hit) ? pcg_pkg::RESP_OKAY : pcg_pkg::RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // External reset pin synchroniser
    always_ff @(posedge aclk) begin
        pin_sync <= {pin_sync[1:0], external_reset_pin_n};
    end

    // Register storage; PLL registers ignore aresetn and clear only on the pin or watchdog reset
    generate
        for (g = 0; g < N; g++) begin : g_reg
            wire is_pll  = (g == pcg_pkg::SLOT_PLL_STATUS)
                        || (g == pcg_pkg::SLOT_PLL_CONTROL);
            wire do_rst  = is_pll ? pll_reset : sys_reset;
            wire [15:0] m = wr_mask[g] & strb_mask;
            always_ff @(posedge aclk) begin
                if (do_rst) begin
                    regs[g] <= pcg_pkg::REG_RESET;
                end else if (wr_allowed && wr_hit[g]) begin
                    regs[g] <= (regs[g] & ~m) | (w_data & m);
                end
            end
        end
    endgenerate

    // Half system clock tick for the CAN controllers
    always_ff @(posedge aclk) begin
        if (sys_reset) begin
            half_tick <= 1'b0;
        end else begin
            half_tick <= !half_tick;
        end
    end

    // Low-speed and high-speed prescaler dividers
    always_ff @(posedge aclk) begin
        if (sys_reset) begin
            ls_cnt  <= 4'h0;
            ls_tick <= 1'b0;
        end else begin
            ls_tick <= (ls_cnt >= ls_last);
            ls_cnt  <= (ls_cnt >= ls_last) ? 4'h0 : ls_cnt + 4'h1;
        end
    end

    always_ff @(posedge aclk) begin
        if (sys_reset) begin
            hs_cnt  <= 4'h0;
            hs_tick <= 1'b0;
        end else begin
            hs_tick <= (hs_cnt >= hs_last);
            hs_cnt  <= (hs_cnt >= hs_last) ? 4'h0 : hs_cnt + 4'h1;
        end
    end

    // Gated pulses; a gate only follows its register while its tick is low
    generate
        for (g = 0; g < 16; g++) begin : g_gate
            always_ff @(posedge aclk) begin
                if (sys_reset) begin
                    applied[g] <= 1'b0;
                    pulse[g]   <= 1'b0;
                end else begin
                    if (!src_tick[g]) begin
                        applied[g] <= regs[pcg_pkg::SLOT_GATE_0][g];
                    end
                    pulse[g] <= applied[g] && src_tick[g];
                end
            end
        end
    endgenerate

    // Peripheral enable map
    assign clk_en.can_b     = pulse[pcg_pkg::BIT_CAN_B];
    assign clk_en.can_a     = pulse[pcg_pkg::BIT_CAN_A];
    assign clk_en.sport_b   = pulse[pcg_pkg::BIT_SPORT_B];
    assign clk_en.sport_a   = pulse[pcg_pkg::BIT_SPORT_A];
    assign clk_en.uart_b    = pulse[pcg_pkg::BIT_UART_B];
    assign clk_en.uart_a    = pulse[pcg_pkg::BIT_UART_A];
    assign clk_en.spi_a     = pulse[pcg_pkg::BIT_SPI_A];
    assign clk_en.uart_c    = pulse[pcg_pkg::BIT_UART_C];
    assign clk_en.i2c       = pulse[pcg_pkg::BIT_I2C];
    assign clk_en.converter = pulse[pcg_pkg::BIT_CONVERTER];

    // Common timebase start for all enabled PWM modules
    assign pwm_timebase_sync = regs[pcg_pkg::SLOT_GATE_0][pcg_pkg::BIT_TB_SYNC];

    // System clock output runs at the CPU input clock rate
    assign system_clock_output = aclk;

endmodule

// ---- dv/pcg_periph_model.sv ----
// Purpose: Peripheral side model counting clock pulses per gated peripheral
// Assumes: One clock; each clk_en pulse is one peripheral clock
// Notes:   clear zeroes every counter at the next edge

`timescale 1ns/1ps

module pcg_periph_model (
    input  wire logic                  aclk,
    input  wire logic                  clear,
    input  wire pcg_pkg::pcg_clk_en_s  clk_en,
    output logic [15:0]                ticks [10]
);
    wire logic [9:0] en_v = clk_en;

    // Each peripheral advances once per received clock pulse
    always_ff @(posedge aclk) begin
        for (int i = 0; i < 10; i++) begin
            if (clear) begin
                ticks[i] <= 16'h0000;
            end else if (en_v[i]) begin
                ticks[i] <= ticks[i] + 16'h0001;
            end
        end
    end
endmodule

// ---- dv/pcg_chk.sv ----
// Purpose: Port-level checks of the clock gating block
// Assumes: Bound to pcg_clock_gate; one clock domain
// Notes:   Bus timings follow the block's hand-over figures

`timescale 1ns/1ps

module pcg_chk (
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    input  wire logic                  s_axi_awvalid,
    input  wire logic                  s_axi_awready,
    input  wire logic                  s_axi_wvalid,
    input  wire logic                  s_axi_wready,
    input  wire logic                  s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic                  s_axi_arvalid,
    input  wire logic                  s_axi_arready,
    input  wire logic [31:0]           s_axi_rdata,
    input  wire logic                  s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    input  wire logic                  system_clock_output,
    input  wire pcg_pkg::pcg_clk_en_s  clk_en,
    input  wire logic                  pwm_timebase_sync
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_wr_done;
        ##1 !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence

    a_can_b_half: assert property (clk_en.can_b |=> !clk_en.can_b)
        else $error("can_b pulse longer than one cycle");
    a_can_a_half: assert property (clk_en.can_a |=> !clk_en.can_a)
        else $error("can_a pulse longer than one cycle");
    a_reset_quiet: assert property ($rose(aresetn) |-> clk_en == '0 && !pwm_timebase_sync)
        else $error("clocks running right after reset");
    a_sysclk_follow: assert property (@(negedge aclk) system_clock_output)
        else $error("system clock output not following input clock");
    a_write_answer: assert property (s_wr_taken |-> s_wr_done)
        else $error("write response not two cycles after take");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after take");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("upper read half not zero");
    a_bvalid_clear: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write response repeated");
    a_rvalid_clear: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read data repeated");
    a_arready_free: assert property (s_axi_arready == !s_axi_rvalid)
        else $error("read address ready wrong");
endmodule

bind pcg_clock_gate pcg_chk u_chk (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .system_clock_output(system_clock_output),
    .clk_en(clk_en), .pwm_timebase_sync(pwm_timebase_sync)
);

// ---- dv/pcg_clock_gate_tb.sv ----
// Purpose: Register and gated clock tests of the clock gating block
// Assumes: Peripheral C UART absent (bit 5) in this build
// Notes:   Counts taken over 40 cycles after each of the ten single-gate writes

`timescale 1ns/1ps

module pcg_clock_gate_tb;
    logic                        aclk, aresetn, pin_n, wd_rst, pwe, clear, sysclk, sync;
    logic [pcg_pkg::ADDR_W-1:0]  awaddr, araddr;
    logic [31:0]                 wdata, rdata;
    logic [1:0]                  bresp, rresp;
    logic                        awvalid, awready, wvalid, wready, bvalid, bready;
    logic                        arvalid, arready, rvalid, rready;
    pcg_pkg::pcg_clk_en_s        clk_en;
    logic [15:0]                 ticks [10];
    int                          err_count, tests_run;
    localparam int               GATE_POS [10] = '{3, 4, 5, 8, 10, 11, 12, 13, 14, 15};
    localparam logic [15:0]      PRESENT       = 16'hffdf;

    pcg_clock_gate #(.PRESENT_MASK(PRESENT)) uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .protected_write_enable(pwe), .external_reset_pin_n(pin_n),
        .watchdog_reset(wd_rst), .system_clock_output(sysclk), .clk_en(clk_en),
        .pwm_timebase_sync(sync));

    pcg_periph_model periph (.aclk(aclk), .clear(clear), .clk_en(clk_en), .ticks(ticks));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic complete_run();
        if (err_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic reg_write(input logic [15:0] idx, input logic [15:0] d, input logic [1:0] er);
        logic done;
        done = 1'b0;
        awaddr  <= {idx, 2'b00};
        wdata   <= {16'h0000, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                done = 1'b1;
                check({30'h0, bresp}, {30'h0, er});
            end
        end
    endtask

    task automatic reg_read(input logic [15:0] idx, input logic [15:0] ed, input logic [1:0] er);
        logic done;
        done = 1'b0;
        araddr  <= {idx, 2'b00};
        arvalid <= 1'b1;
        while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                done = 1'b1;
                check(rdata, {16'h0000, ed});
                check({30'h0, rresp}, {30'h0, er});
            end
        end
    endtask

    // Only the enabled peripheral counts; CAN at half rate, converter N=1, others N=2
    task automatic count_check(input int j);
        clear <= 1'b1;
        @(posedge aclk);
        clear <= 1'b0;
        repeat (40) @(posedge aclk);
        @(negedge aclk);
        for (int k = 0; k < 10; k++) begin
            check({16'h0, ticks[k]}, (k != j || !PRESENT[GATE_POS[k]]) ? 32'h0 : (k == 0 || k >= 8) ? 32'h14 : 32'ha);
        end
        @(posedge aclk);
    endtask

    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    initial begin
        repeat (20000) @(posedge aclk);
        err_count++;
        complete_run();
    end

    initial begin
        err_count = 0;
        tests_run = 0;
        {aresetn, pin_n, wd_rst, clear, awvalid, wvalid, arvalid} <= 7'h00;
        {pwe, bready, rready} <= 3'h7;
        awaddr <= '0;
        araddr <= '0;
        wdata  <= 32'h0;
        repeat (10) @(posedge aclk);
        pin_n <= 1'b1;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_read(pcg_pkg::IDX_GATE_0, pcg_pkg::GATE0_RESET, pcg_pkg::RESP_OKAY);
        reg_write(pcg_pkg::IDX_GATE_0, PRESENT, pcg_pkg::RESP_OKAY);
        reg_read(pcg_pkg::IDX_GATE_0, 16'hfd1c, pcg_pkg::RESP_OKAY);
        pwe <= 1'b0;
        reg_write(pcg_pkg::IDX_GATE_0, 16'h0000, pcg_pkg::RESP_OKAY);
        pwe <= 1'b1;
        reg_read(pcg_pkg::IDX_GATE_0, 16'hfd1c, pcg_pkg::RESP_OKAY);
        reg_write(pcg_pkg::IDX_LS_PRESCALER, 16'h0002, pcg_pkg::RESP_OKAY);
        reg_write(pcg_pkg::IDX_HS_PRESCALER, 16'h0001, pcg_pkg::RESP_OKAY);
        reg_read(pcg_pkg::IDX_LS_PRESCALER, 16'h0002, pcg_pkg::RESP_OKAY);
        for (int j = 0; j < 10; j++) begin
            reg_write(pcg_pkg::IDX_GATE_0, (16'h0001 << GATE_POS[j]) & PRESENT, pcg_pkg::RESP_OKAY);
            repeat (8) @(posedge aclk);
            count_check(j);
        end
        reg_write(pcg_pkg::IDX_GATE_0, 16'h0004, pcg_pkg::RESP_OKAY);
        repeat (2) @(posedge aclk);
        check({31'h0, sync}, 32'h1);
        reg_read(16'h7012, 16'h0000, pcg_pkg::RESP_SLVERR);
        reg_write(16'h7012, 16'h1234, pcg_pkg::RESP_SLVERR);
        reg_write(pcg_pkg::IDX_PLL_CONTROL, 16'h000a, pcg_pkg::RESP_OKAY);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        reg_read(pcg_pkg::IDX_PLL_CONTROL, 16'h000a, pcg_pkg::RESP_OKAY);
        reg_read(pcg_pkg::IDX_GATE_0, pcg_pkg::GATE0_RESET, pcg_pkg::RESP_OKAY);
        wd_rst <= 1'b1;
        @(posedge aclk);
        wd_rst <= 1'b0;
        repeat (2) @(posedge aclk);
        reg_read(pcg_pkg::IDX_PLL_CONTROL, pcg_pkg::REG_RESET, pcg_pkg::RESP_OKAY);
        reg_write(pcg_pkg::IDX_PLL_STATUS, 16'h0005, pcg_pkg::RESP_OKAY);
        reg_read(pcg_pkg::IDX_PLL_STATUS, 16'h0005, pcg_pkg::RESP_OKAY);
        pin_n <= 1'b0;
        repeat (5) @(posedge aclk);
        pin_n <= 1'b1;
        repeat (5) @(posedge aclk);
        reg_read(pcg_pkg::IDX_PLL_STATUS, pcg_pkg::REG_RESET, pcg_pkg::RESP_OKAY);
        complete_run();
    end
endmodule
